// [src/rblc_map.svh]
// register map, switch positions, message codes and boot constants of the boot loader
`ifndef RBLC_MAP_SVH
`define RBLC_MAP_SVH
`define RBLC_OFF_CTRL      8'h00
`define RBLC_OFF_STATUS    8'h04
`define RBLC_OFF_ADDRSW    8'h08
`define RBLC_OFF_XFER      8'h0c
`define RBLC_CTRL_BOOT     0
`define RBLC_CTRL_MCLR     1
`define RBLC_CTRL_DUPLEX   2
`define RBLC_CTRL_NET_LO   3
`define RBLC_CTRL_RST      3'h0
`define RBLC_ST_UNIT_LO    12
`define RBLC_ST_DUPLEX     16
`define RBLC_ST_NET_LO     17
`define RBLC_ST_RLD_EN     19
`define RBLC_ST_PON_EN     20
`define RBLC_ST_READY      21
`define RBLC_SW_UNIT_LO    0
`define RBLC_SW_DUPLEX     4
`define RBLC_SW_NET_LO     5
`define RBLC_SW_MODE_EN    7
`define RBLC_SW_RLD        8
`define RBLC_SW_PON        9
`define RBLC_MSG_ENTER     2'h1
`define RBLC_MSG_POLL      2'h2
`define RBLC_MSG_LOAD      2'h3
`define RBLC_PTP_NODE      8'h01
`define RBLC_LOOP_BASE     16'h0100
`define RBLC_LOOP_WORD     16'h01ff
`define RBLC_PF_VECTOR     16'h0014
`define RBLC_PF_PSW        16'h00e0
`define RBLC_STOP_WORDS    3
`define RBLC_WORD_STEP     16'h0002
`endif

// [src/rblc_pkg.sv]
// types shared by the boot loader modules
package rblc_pkg;
  typedef enum logic [8:0] {
    RBLC_IDLE = 9'h001,
    RBLC_STOP = 9'h002,
    RBLC_FIRE = 9'h004,
    RBLC_POLL = 9'h008,
    RBLC_REQ  = 9'h010,
    RBLC_HDR  = 9'h020,
    RBLC_DATA = 9'h040,
    RBLC_GO   = 9'h080,
    RBLC_WAIT = 9'h100
  } rblc_state_t;
  typedef enum logic [1:0] {
    RBLC_NET_PTP_LEGACY = 2'h0,
    RBLC_NET_PTP        = 2'h1,
    RBLC_NET_MP_CTRL    = 2'h2,
    RBLC_NET_MP_TRIB    = 2'h3
  } rblc_net_t;
endpackage : rblc_pkg

// [src/rblc_strap.sv]
// strap sampler: catches both switch packs once after reset and decodes them
`timescale 1ns/1ps
`include "rblc_map.svh"
module rblc_strap (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [9:0]  i_cfg_sw,
  input  wire logic [7:0]  i_addr_sw,
  output logic             o_ready,
  output logic [3:0]       o_unit,
  output logic             o_mode_en,
  output logic             o_full_duplex,
  output rblc_pkg::rblc_net_t o_net,
  output logic             o_rld_en,
  output logic             o_pon_en,
  output logic [7:0]       o_trib_addr
);
  import rblc_pkg::*;
  logic [9:0] cfg_ff;
  logic [7:0] adr_ff;
  logic       rdy_ff;
  // switches are caught on the first edge after release, then frozen
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rdy_ff <= 1'b0;
      // cleared so the mode outputs show no unknown before the capture
      cfg_ff <= '0;
      adr_ff <= '0;
    end else if (!rdy_ff) begin
      rdy_ff <= 1'b1;
      cfg_ff <= i_cfg_sw;
      adr_ff <= i_addr_sw;
    end
  end
  assign o_ready       = rdy_ff;
  assign o_unit        = cfg_ff[`RBLC_SW_UNIT_LO +: 4];
  assign o_mode_en     = cfg_ff[`RBLC_SW_MODE_EN];
  assign o_full_duplex = cfg_ff[`RBLC_SW_DUPLEX];
  assign o_net         = rblc_net_t'({cfg_ff[`RBLC_SW_NET_LO+1], cfg_ff[`RBLC_SW_NET_LO]});
  assign o_rld_en      = cfg_ff[`RBLC_SW_RLD];
  assign o_pon_en      = ~cfg_ff[`RBLC_SW_PON];
  assign o_trib_addr   = adr_ff;
endmodule : rblc_strap

// [src/rblc_dma.sv]
// single-word dma writer into host memory, request held until acknowledged
`timescale 1ns/1ps
module rblc_dma #(
  parameter int AW = 16,
  parameter int DW = 16
) (
  input  wire logic          i_clk,
  input  wire logic          i_rstn,
  input  wire logic          i_start,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_data,
  input  wire logic          i_ack,
  output logic               o_busy,
  output logic               o_done,
  output logic [AW-1:0]      o_addr,
  output logic [DW-1:0]      o_data
);
  logic busy_ff;
  logic done_ff;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      o_addr  <= '0;
      o_data  <= '0;
    end else begin
      done_ff <= busy_ff & i_ack;
      if (busy_ff && i_ack) begin
        busy_ff <= 1'b0;
      end else if (!busy_ff && i_start) begin
        busy_ff <= 1'b1;
        o_addr  <= i_addr;
        o_data  <= i_data;
      end
    end
  end
  assign o_busy = busy_ff;
  assign o_done = done_ff;
endmodule : rblc_dma

// [src/rblc_top.sv]
// remote boot loader: maintenance-protocol boot sequencer with host dma and ahb-lite registers
`timescale 1ns/1ps
`include "rblc_map.svh"
// What this block does
// - enter message accepted only after address and password check, then host stopped.
// - stop host by dma of a tight loop, then jump through power-fail vector.
// - after host is stopped, send a request-program message.
// - dma the program into host memory, then start it at the transfer address.
// - power-on boot skips enter step, answers first poll with request-program.
// - software writing boot and master-clear together runs the power-on sequence.
// - four-bit unit number from switches 1..4, readable by the boot program.
// - mode comes from switches when mode-enable switch 8 is one.
// - switches 5,6,7 decode duplex and network kind.
// - power-on boot enabled only when switch 10 is zero.
// - eight-bit tributary address from second switch pack, switch 1 lsb.
// - point-to-point power-on boot does not use the address switches.
// - remote-load boot enabled only when switch 9 is one.
// - address switches are the password an enter message must match.
// - point-to-point node address is always one; switches only guard password.
module rblc_top (
  input  wire logic        I_CLK,
  input  wire logic        I_RSTN,
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  input  wire logic [9:0]  I_CONFIG_SWITCH_PACK,
  input  wire logic [7:0]  I_ADDRESS_SWITCH_PACK,
  input  wire logic        I_RX_VALID,
  input  wire logic [1:0]  I_RX_KIND,
  input  wire logic [7:0]  I_RX_NODE,
  input  wire logic [7:0]  I_RX_PASSWORD,
  input  wire logic [15:0] I_RX_DATA,
  input  wire logic        I_RX_LAST,
  output logic             O_RX_READY,
  output logic             O_TX_REQ_PROGRAM,
  input  wire logic        I_TX_READY,
  output logic             O_DMA_TRANSFER_REQ,
  output logic      [15:0] O_DMA_TRANSFER_ADDR,
  output logic      [15:0] O_DMA_TRANSFER_DATA,
  input  wire logic        I_DMA_TRANSFER_ACK,
  output logic             O_POWER_FAIL_VECTOR,
  output logic             O_HOST_START,
  output logic      [15:0] O_HOST_START_ADDR,
  output rblc_pkg::rblc_net_t O_NET_MODE,
  output logic             O_FULL_DUPLEX
);
  import rblc_pkg::*;

  // word list that stops the host: loop routine, then vector pc and psw
  function automatic logic [31:0] stop_word(input logic [1:0] idx);
    unique case (idx)
      2'h0:    stop_word = {`RBLC_LOOP_BASE, `RBLC_LOOP_WORD};
      2'h1:    stop_word = {`RBLC_PF_VECTOR, `RBLC_LOOP_BASE};
      default: stop_word = {`RBLC_PF_VECTOR + `RBLC_WORD_STEP, `RBLC_PF_PSW};
    endcase
  endfunction : stop_word

  // strap values
  logic        strap_rdy;
  logic [3:0]  sw_unit;
  logic        sw_mode_en;
  logic        sw_duplex;
  rblc_net_t   sw_net;
  logic        rld_en;
  logic        pon_en;
  logic [7:0]  trib_addr;

  rblc_strap u_strap (
    .i_clk         (I_CLK),
    .i_rstn        (I_RSTN),
    .i_cfg_sw      (I_CONFIG_SWITCH_PACK),
    .i_addr_sw     (I_ADDRESS_SWITCH_PACK),
    .o_ready       (strap_rdy),
    .o_unit        (sw_unit),
    .o_mode_en     (sw_mode_en),
    .o_full_duplex (sw_duplex),
    .o_net         (sw_net),
    .o_rld_en      (rld_en),
    .o_pon_en      (pon_en),
    .o_trib_addr   (trib_addr)
  );

  // state and registers
  rblc_state_t state_ff;
  rblc_state_t nxt_state;
  logic [1:0]  stop_idx_ff;
  logic        need_poll_ff;
  logic        pon_pend_ff;
  logic        invoke_ff;
  logic        sw_duplex_ff;
  logic [1:0]  sw_net_ff;
  logic [15:0] load_addr_ff;
  logic [15:0] xfer_ff;
  logic        rx_rdy_ff;
  logic        tx_ff;
  logic        pf_ff;
  logic        go_ff;

  // ahb-lite slave, zero wait states
  logic        ap_wr_ff;
  logic [7:0]  ap_addr_ff;
  wire         ap_take  = I_HSEL & I_HTRANS[1] & I_HREADY;
  wire  [7:0]  ap_off   = I_HADDR[7:0];
  wire         wr_ctrl  = ap_wr_ff & (ap_addr_ff == `RBLC_OFF_CTRL);
  wire         wr_boot  = wr_ctrl & I_HWDATA[`RBLC_CTRL_BOOT] & I_HWDATA[`RBLC_CTRL_MCLR];
  wire         wr_mclr  = wr_ctrl & I_HWDATA[`RBLC_CTRL_MCLR] & ~I_HWDATA[`RBLC_CTRL_BOOT];

  // active mode: strapped when mode-enable is one, else the software mode
  wire         eff_duplex = sw_mode_en ? sw_duplex : sw_duplex_ff;
  wire  [1:0]  eff_net    = sw_mode_en ? sw_net : sw_net_ff;
  wire         is_ptp     = ~eff_net[1];
  // point-to-point node is fixed at one; switches then only guard the password
  wire  [7:0]  my_node    = is_ptp ? `RBLC_PTP_NODE : trib_addr;
  wire         node_hit   = (I_RX_NODE == my_node);

  wire  [31:0] rd_status = {10'h0, strap_rdy, pon_en, rld_en, eff_net, eff_duplex,
                            sw_unit, 3'h0, state_ff};
  wire  [31:0] rd_ctrl   = {27'h0, sw_net_ff, sw_duplex_ff, 2'h0};
  wire  [31:0] rd_mux    = (ap_off == `RBLC_OFF_CTRL)   ? rd_ctrl :
                           (ap_off == `RBLC_OFF_STATUS) ? rd_status :
                           (ap_off == `RBLC_OFF_ADDRSW) ? {24'h0, trib_addr} :
                           (ap_off == `RBLC_OFF_XFER)   ? {16'h0, xfer_ff} : 32'h0;

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      ap_wr_ff     <= 1'b0;
      ap_addr_ff   <= 8'h00;
      O_HRDATA     <= 32'h0;
      O_HREADYOUT  <= 1'b0;
      O_HRESP      <= 1'b0;
      sw_duplex_ff <= 1'(`RBLC_CTRL_RST >> `RBLC_CTRL_DUPLEX);
      sw_net_ff    <= 2'h0;
    end else begin
      O_HREADYOUT <= 1'b1;
      ap_wr_ff    <= ap_take & I_HWRITE;
      ap_addr_ff  <= ap_off;
      if (ap_take && !I_HWRITE) begin
        O_HRDATA <= rd_mux;
      end
      if (wr_ctrl) begin
        sw_duplex_ff <= I_HWDATA[`RBLC_CTRL_DUPLEX];
        sw_net_ff    <= I_HWDATA[`RBLC_CTRL_NET_LO +: 2];
      end
    end
  end

  // message handshakes
  wire rx_take   = I_RX_VALID & rx_rdy_ff;
  wire is_enter  = rx_take & (I_RX_KIND == `RBLC_MSG_ENTER);
  wire is_poll   = rx_take & (I_RX_KIND == `RBLC_MSG_POLL) & node_hit;
  wire is_load   = rx_take & (I_RX_KIND == `RBLC_MSG_LOAD);
  // remote-load boot needs the strap enable, our node and the password
  wire enter_ok  = is_enter & rld_en & node_hit & (I_RX_PASSWORD == trib_addr);
  wire tx_done   = tx_ff & I_TX_READY;

  // dma engine
  logic        dma_busy;
  logic        dma_done;
  wire  [31:0] sw_word   = stop_word(stop_idx_ff);
  wire         stop_kick = (state_ff == RBLC_STOP) & ~dma_busy;
  wire         data_kick = (state_ff == RBLC_DATA) & is_load & ~I_RX_LAST;
  wire  [15:0] dma_addr  = stop_kick ? sw_word[31:16] : load_addr_ff;
  wire  [15:0] dma_data  = stop_kick ? sw_word[15:0] : I_RX_DATA;

  rblc_dma #(
    .AW (16),
    .DW (16)
  ) u_dma (
    .i_clk   (I_CLK),
    .i_rstn  (I_RSTN),
    .i_start (stop_kick | data_kick),
    .i_addr  (dma_addr),
    .i_data  (dma_data),
    .i_ack   (I_DMA_TRANSFER_ACK),
    .o_busy  (O_DMA_TRANSFER_REQ),
    .o_done  (dma_done),
    .o_addr  (O_DMA_TRANSFER_ADDR),
    .o_data  (O_DMA_TRANSFER_DATA)
  );
  assign dma_busy = O_DMA_TRANSFER_REQ;

  wire last_stop = (stop_idx_ff == 2'(`RBLC_STOP_WORDS - 1));

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      RBLC_IDLE: begin
        // nothing runs before the switches are caught
        if (strap_rdy && (invoke_ff || (pon_pend_ff && pon_en))) begin
          nxt_state = RBLC_STOP;
        end else if (enter_ok) begin
          nxt_state = RBLC_STOP;
        end
      end
      RBLC_STOP: begin
        if (stop_kick && last_stop) begin
          nxt_state = RBLC_WAIT;
        end
      end
      RBLC_WAIT: begin
        if (dma_done) begin
          nxt_state = RBLC_FIRE;
        end
      end
      RBLC_FIRE: begin
        nxt_state = need_poll_ff ? RBLC_POLL : RBLC_REQ;
      end
      RBLC_POLL: begin
        if (is_poll) begin
          nxt_state = RBLC_REQ;
        end
      end
      RBLC_REQ: begin
        if (tx_done) begin
          nxt_state = RBLC_HDR;
        end
      end
      RBLC_HDR: begin
        if (is_load) begin
          nxt_state = I_RX_LAST ? RBLC_GO : RBLC_DATA;
        end
      end
      RBLC_DATA: begin
        if (is_load && I_RX_LAST) begin
          nxt_state = RBLC_GO;
        end
      end
      RBLC_GO: begin
        if (!dma_busy) begin
          nxt_state = RBLC_IDLE;
        end
      end
      default: nxt_state = RBLC_IDLE;
    endcase
    if (wr_mclr) begin
      nxt_state = RBLC_IDLE;
    end
  end

  wire nxt_accepts = (nxt_state == RBLC_IDLE) | (nxt_state == RBLC_POLL) |
                     (nxt_state == RBLC_HDR) | (nxt_state == RBLC_DATA);
  wire starting    = (state_ff == RBLC_IDLE) & (nxt_state == RBLC_STOP);

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      state_ff     <= RBLC_IDLE;
      stop_idx_ff  <= 2'h0;
      need_poll_ff <= 1'b0;
      pon_pend_ff  <= 1'b1;
      invoke_ff    <= 1'b0;
      load_addr_ff <= 16'h0;
      xfer_ff      <= 16'h0;
      rx_rdy_ff    <= 1'b0;
      tx_ff        <= 1'b0;
      pf_ff        <= 1'b0;
      go_ff        <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      // hold off the line while a word is still going to memory
      rx_rdy_ff <= strap_rdy & nxt_accepts & ~rx_take & (~dma_busy | dma_done);
      pf_ff     <= (state_ff == RBLC_WAIT) & dma_done;
      tx_ff     <= (nxt_state == RBLC_REQ) & ~tx_done;
      go_ff     <= (state_ff == RBLC_GO) & ~dma_busy;
      // a new request in the cycle it is consumed still wins
      if (wr_boot) begin
        invoke_ff <= 1'b1;
      end else if (starting) begin
        invoke_ff <= 1'b0;
      end
      if (strap_rdy && (starting || !pon_en)) begin
        pon_pend_ff <= 1'b0;
      end
      if (starting) begin
        stop_idx_ff  <= 2'h0;
        need_poll_ff <= ~enter_ok | invoke_ff | (pon_pend_ff & pon_en);
      end else if (stop_kick) begin
        stop_idx_ff <= stop_idx_ff + 2'h1;
      end
      if (state_ff == RBLC_HDR && is_load) begin
        load_addr_ff <= I_RX_DATA;
        if (I_RX_LAST) begin
          xfer_ff <= I_RX_DATA;
        end
      end else if (data_kick) begin
        load_addr_ff <= load_addr_ff + `RBLC_WORD_STEP;
      end else if (state_ff == RBLC_DATA && is_load) begin
        xfer_ff <= I_RX_DATA;
      end
    end
  end

  // mode outputs registered here so the top drives them from flops
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_NET_MODE        <= RBLC_NET_PTP_LEGACY;
      O_FULL_DUPLEX     <= 1'b0;
      O_HOST_START_ADDR <= 16'h0;
    end else begin
      O_NET_MODE    <= rblc_net_t'(eff_net);
      O_FULL_DUPLEX <= eff_duplex;
      if ((state_ff == RBLC_GO) && !dma_busy) begin
        O_HOST_START_ADDR <= xfer_ff;
      end
    end
  end

  assign O_RX_READY          = rx_rdy_ff;
  assign O_TX_REQ_PROGRAM    = tx_ff;
  assign O_POWER_FAIL_VECTOR = pf_ff;
  assign O_HOST_START        = go_ff;
endmodule : rblc_top

// [verification/rblc_top_assertions.sv]
// port checker for the remote boot loader
`timescale 1ns/1ps
module rblc_chk (
  input wire logic                I_CLK,
  input wire logic                I_RSTN,
  input wire logic [9:0]          I_CONFIG_SWITCH_PACK,
  input wire logic                I_RX_VALID,
  input wire logic                O_RX_READY,
  input wire logic                O_TX_REQ_PROGRAM,
  input wire logic                I_TX_READY,
  input wire logic                O_DMA_TRANSFER_REQ,
  input wire logic [15:0]         O_DMA_TRANSFER_ADDR,
  input wire logic [15:0]         O_DMA_TRANSFER_DATA,
  input wire logic                I_DMA_TRANSFER_ACK,
  input wire logic                O_POWER_FAIL_VECTOR,
  input wire logic                O_HOST_START,
  input wire logic                O_HREADYOUT,
  input wire logic                O_HRESP,
  input wire rblc_pkg::rblc_net_t O_NET_MODE,
  input wire logic                O_FULL_DUPLEX
);
  import rblc_pkg::*;
  // cycles since reset release, saturating so long runs stay cheap
  logic [2:0] up_ff;
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) up_ff <= 3'h0;
    else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  a_dma_req_hold: assert property (
    O_DMA_TRANSFER_REQ && !I_DMA_TRANSFER_ACK |=> O_DMA_TRANSFER_REQ
    && $stable(O_DMA_TRANSFER_ADDR) && $stable(O_DMA_TRANSFER_DATA))
    else $error("dma request changed before ack");
  a_vector_after_ack: assert property (
    O_POWER_FAIL_VECTOR |-> $past(I_DMA_TRANSFER_ACK && O_DMA_TRANSFER_REQ, 2)
    ##1 !O_POWER_FAIL_VECTOR)
    else $error("vector pulse not two cycles after last ack");
  a_start_pulse: assert property (
    O_HOST_START |-> !O_DMA_TRANSFER_REQ ##1 !O_HOST_START)
    else $error("host start with dma busy or too long");
  a_tx_req_hold: assert property (
    O_TX_REQ_PROGRAM && !I_TX_READY |=> O_TX_REQ_PROGRAM)
    else $error("request message withdrawn");
  a_rx_take_gap: assert property (
    I_RX_VALID && O_RX_READY |=> !O_RX_READY)
    else $error("rx ready held after a take");
  a_bus_ready: assert property (up_ff != 3'h0 |-> O_HREADYOUT && !O_HRESP)
    else $error("bus not ready or not okay");
  a_strap_mode: assert property (
    up_ff == 3'h7 && I_CONFIG_SWITCH_PACK[7] |-> O_NET_MODE == I_CONFIG_SWITCH_PACK[6:5]
    && O_FULL_DUPLEX == I_CONFIG_SWITCH_PACK[4])
    else $error("strapped mode not on mode outputs");
  a_dma_after_strap: assert property (
    O_DMA_TRANSFER_REQ |-> up_ff >= 3'h2)
    else $error("dma before switches captured");
endmodule : rblc_chk
bind rblc_top rblc_chk i_rblc_chk (.I_CLK, .I_RSTN, .I_CONFIG_SWITCH_PACK, .I_RX_VALID,
  .O_RX_READY, .O_TX_REQ_PROGRAM, .I_TX_READY, .O_DMA_TRANSFER_REQ, .O_DMA_TRANSFER_ADDR,
  .O_DMA_TRANSFER_DATA, .I_DMA_TRANSFER_ACK, .O_POWER_FAIL_VECTOR, .O_HOST_START,
  .O_HREADYOUT, .O_HRESP, .O_NET_MODE, .O_FULL_DUPLEX);

// [verification/rblc_station.sv]
// control station and host memory model on the far side of the boot loader
`timescale 1ns/1ps
module rblc_station (
  input  wire logic        i_clk,
  input  wire logic        i_rx_ready,
  input  wire logic        i_tx_req,
  input  wire logic        i_dma_req,
  input  wire logic [15:0] i_dma_addr,
  input  wire logic [15:0] i_dma_data,
  output logic             o_rx_valid,
  output logic [1:0]       o_rx_kind,
  output logic [7:0]       o_rx_node,
  output logic [7:0]       o_rx_pw,
  output logic [15:0]      o_rx_data,
  output logic             o_rx_last,
  output logic             o_tx_ready,
  output logic             o_dma_ack
);
  logic [31:0] log_q[$];
  int          slow = 0;
  int          dly = 0;
  int          n_req = 0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_kind = 2'h0;
    o_rx_node = 8'h0;
    o_rx_pw = 8'h0;
    o_rx_data = 16'h0;
    o_rx_last = 1'b0;
    o_tx_ready = 1'b0;
    o_dma_ack = 1'b0;
  end
  // beats are held until taken; called just after a rising edge
  task automatic msg(input logic [1:0] k, input logic [7:0] n, input logic [7:0] p,
                     input logic [15:0] w[$]);
    foreach (w[i]) begin
      o_rx_valid <= 1'b1;
      o_rx_kind <= k;
      o_rx_node <= n;
      o_rx_pw <= p;
      o_rx_data <= w[i];
      o_rx_last <= (i == w.size() - 1);
      do @(posedge i_clk); while (!i_rx_ready);
    end
    // released lines must not keep showing the last beat
    o_rx_valid <= 1'b0;
    o_rx_kind <= ~o_rx_kind;
    o_rx_node <= ~o_rx_node;
    o_rx_pw <= ~o_rx_pw;
    o_rx_data <= ~o_rx_data;
    // let one edge pass so a following message does not reassign valid at once
    @(posedge i_clk);
  endtask : msg
  always @(posedge i_clk) begin
    o_dma_ack <= 1'b0;
    o_tx_ready <= i_tx_req && !o_tx_ready;
    if (i_tx_req && o_tx_ready) n_req++;
    if (i_dma_req && !o_dma_ack) begin
      if (dly < slow) dly++;
      else begin
        o_dma_ack <= 1'b1;
        log_q.push_back({i_dma_addr, i_dma_data});
        dly = 0;
      end
    end
  end
endmodule : rblc_station

// [verification/tb_rblc_top.sv]
// self-checking bench for the remote boot loader
`timescale 1ns/1ps
`include "rblc_map.svh"
module tb_rblc_top;
  import rblc_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0, rx_kind;
  logic [9:0]  cfg = 10'h380;
  logic [7:0]  asw = 8'h0, rx_node, rx_pw;
  logic        hready, hresp, rx_ready, rx_valid, rx_last, tx_req, tx_ready;
  logic        dreq, dack, pfv, hstart, fdx;
  logic [15:0] rx_data, daddr, ddata, saddr, lf = 16'hee20;
  rblc_net_t   net;
  int          miscompares = 0, n_tests = 0, n_pfv = 0, n_start = 0;
  logic [31:0] stop_w[3] = '{{`RBLC_LOOP_BASE, `RBLC_LOOP_WORD},
    {`RBLC_PF_VECTOR, `RBLC_LOOP_BASE}, {`RBLC_PF_VECTOR + `RBLC_WORD_STEP, `RBLC_PF_PSW}};
  rblc_top i_rblc_top (.I_CLK(clk), .I_RSTN(rstn), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_CONFIG_SWITCH_PACK(cfg),
    .I_ADDRESS_SWITCH_PACK(asw), .I_RX_VALID(rx_valid), .I_RX_KIND(rx_kind),
    .I_RX_NODE(rx_node), .I_RX_PASSWORD(rx_pw), .I_RX_DATA(rx_data), .I_RX_LAST(rx_last),
    .O_RX_READY(rx_ready), .O_TX_REQ_PROGRAM(tx_req), .I_TX_READY(tx_ready),
    .O_DMA_TRANSFER_REQ(dreq), .O_DMA_TRANSFER_ADDR(daddr), .O_DMA_TRANSFER_DATA(ddata),
    .I_DMA_TRANSFER_ACK(dack), .O_POWER_FAIL_VECTOR(pfv), .O_HOST_START(hstart),
    .O_HOST_START_ADDR(saddr), .O_NET_MODE(net), .O_FULL_DUPLEX(fdx));
  rblc_station i_rblc_station (.i_clk(clk), .i_rx_ready(rx_ready), .i_tx_req(tx_req),
    .i_dma_req(dreq), .i_dma_addr(daddr), .i_dma_data(ddata), .o_rx_valid(rx_valid),
    .o_rx_kind(rx_kind), .o_rx_node(rx_node), .o_rx_pw(rx_pw), .o_rx_data(rx_data),
    .o_rx_last(rx_last), .o_tx_ready(tx_ready), .o_dma_ack(dack));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    n_pfv += pfv;
    n_start += hstart;
  end
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nxt
  function automatic logic [31:0] exp_st(input logic [9:0] c, input logic [8:0] s);
    return {10'h0, 1'b1, ~c[9], c[8], c[6:5], c[4], c[3:0], 3'h0, s};
  endfunction : exp_st
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (!hready);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (!hready);
    r = hrdata;
  endtask : ahb
  task automatic wait_cnt(ref int v, input int t);
    for (int k = 0; k < 400 && v < t; k++) @(posedge clk);
  endtask : wait_cnt
  task automatic reset_to(input logic [9:0] c, input logic [7:0] a);
    rstn <= 1'b0;
    cfg <= c;
    asw <= a;
    i_rblc_station.log_q.delete();
    i_rblc_station.n_req = 0;
    n_pfv = 0;
    n_start = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : reset_to
  // host stop, optional poll, request, program load and start
  task automatic boot(input logic [7:0] nd, input logic poll);
    logic [15:0] w[$];
    logic [31:0] r;
    int          k;
    wait_cnt(n_pfv, 1);
    chk(n_pfv, 1);
    for (int i = 0; i < 3; i++) chk(i_rblc_station.log_q[i], stop_w[i]);
    if (poll) begin
      repeat (20) @(posedge clk);
      chk(i_rblc_station.n_req, 0);
      i_rblc_station.msg(`RBLC_MSG_POLL, nd, asw, {lf});
    end
    wait_cnt(i_rblc_station.n_req, 1);
    chk(i_rblc_station.n_req, 1);
    lf = nxt(lf);
    k = 1 + lf[1:0];
    w = {lf & 16'hfffe};
    for (int i = 0; i <= k; i++) begin
      lf = nxt(lf);
      w.push_back(i == k ? lf & 16'hfffe : lf);
    end
    i_rblc_station.msg(`RBLC_MSG_LOAD, nd, asw, w);
    wait_cnt(n_start, 1);
    chk(n_start, 1);
    chk(saddr, w[k + 1]);
    chk(i_rblc_station.log_q.size(), 3 + k);
    for (int i = 0; i < k; i++)
      chk(i_rblc_station.log_q[3 + i], {w[0] + 16'(2 * i), w[i + 1]});
    ahb(1'b0, `RBLC_OFF_XFER, 32'h0, r);
    chk(r, {16'h0, w[k + 1]});
  endtask : boot
  initial begin
    #200us;
    miscompares++;
    results();
  end
  initial begin
    logic [31:0] r;
    logic [9:0]  c;
    logic [7:0]  a, nd, wn;
    logic [1:0]  nets[2] = '{2'h3, 2'h1};
    for (int i = 0; i < 8; i++) begin
      lf = nxt(lf);
      c = {1'b1, lf[8], 1'b1, 3'(i), lf[3:0]};
      a = lf[15:8];
      reset_to(c, a);
      ahb(1'b0, `RBLC_OFF_STATUS, 32'h0, r);
      chk(r, exp_st(c, 9'h001));
      chk(net, c[6:5]);
      chk(fdx, c[4]);
      ahb(1'b0, `RBLC_OFF_ADDRSW, 32'h0, r);
      chk(r, {24'h0, a});
      cfg <= c ^ 10'h00f;
      asw <= ~a;
      ahb(1'b0, `RBLC_OFF_STATUS, 32'h0, r);
      chk(r, exp_st(c, 9'h001));
      ahb(1'b0, `RBLC_OFF_ADDRSW, 32'h0, r);
      chk(r, {24'h0, a});
    end
    reset_to(10'h300, 8'h21);
    ahb(1'b1, `RBLC_OFF_CTRL, 32'h14, r);
    ahb(1'b0, 8'h20, 32'h0, r);
    chk(r, 32'h0);
    chk(net, 2'h2);
    chk(fdx, 1'b1);
    foreach (nets[j]) begin
      lf = nxt(lf);
      a = lf[7:0] | 8'h02;
      c = {1'b1, 1'b1, 1'b1, nets[j], lf[12], lf[11:8]};
      reset_to(c, a);
      i_rblc_station.slow = j * 3;
      nd = (nets[j] == 2'h1) ? `RBLC_PTP_NODE : a;
      wn = (nets[j] == 2'h1) ? a : ~a;
      i_rblc_station.msg(`RBLC_MSG_ENTER, nd, a ^ 8'h10, {lf});
      i_rblc_station.msg(`RBLC_MSG_ENTER, wn, a, {lf});
      repeat (10) @(posedge clk);
      chk(i_rblc_station.log_q.size(), 0);
      ahb(1'b0, `RBLC_OFF_STATUS, 32'h0, r);
      chk(r, exp_st(c, 9'h001));
      i_rblc_station.msg(`RBLC_MSG_ENTER, nd, a, {lf});
      boot(nd, 1'b0);
    end
    reset_to(10'h0f5, 8'h5a);
    boot(8'h5a, 1'b1);
    reset_to(10'h2ea, 8'h3c);
    i_rblc_station.msg(`RBLC_MSG_ENTER, 8'h3c, 8'h3c, {lf});
    repeat (10) @(posedge clk);
    chk(i_rblc_station.log_q.size(), 0);
    ahb(1'b1, `RBLC_OFF_CTRL, 32'h1, r);
    repeat (10) @(posedge clk);
    chk(i_rblc_station.log_q.size(), 0);
    ahb(1'b1, `RBLC_OFF_CTRL, 32'h3, r);
    wait_cnt(n_pfv, 1);
    ahb(1'b1, `RBLC_OFF_CTRL, 32'h2, r);
    ahb(1'b0, `RBLC_OFF_STATUS, 32'h0, r);
    chk(r, exp_st(10'h2ea, 9'h001));
    n_pfv = 0;
    i_rblc_station.log_q.delete();
    ahb(1'b1, `RBLC_OFF_CTRL, 32'h3, r);
    boot(8'h3c, 1'b1);
    results();
  end
endmodule : tb_rblc_top
